// >>> logic/rtcc_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RTCC_CONSTS_SVH
`define RTCC_CONSTS_SVH
`define RTCC_OFF_TICK_CONTROL 12'h018
`define RTCC_OFF_IRQ_ENABLE 12'h01c
`define RTCC_OFF_IRQ_RAW 12'h020
`define RTCC_OFF_IRQ_MASKED 12'h024
`define RTCC_OFF_IRQ_CLEAR 12'h028
`define RTCC_DIV_LSB 0
`define RTCC_DIV_MSB 14
`define RTCC_TRIM_LSB 16
`define RTCC_TRIM_MSB 25
`define RTCC_LOCK_BIT 26
`define RTCC_CAL_BIT 0
`define RTCC_TMR_BIT 1
`define RTCC_DIV_RESET 15'h7fff
`define RTCC_TRIM_RESET 10'h000
`define RTCC_TRIM_PERIOD 10'h3ff
`define RTCC_TMR_RESET 32'h0000_0000
`endif

// >>> logic/rtcc_pkg.sv
// Types shared by the tick control block
package rtcc_pkg;
  typedef logic [1:0] rtcc_irq_t;
  typedef enum logic [1:0] {
    RTCC_TMR_IDLE,
    RTCC_TMR_RUN
  } rtcc_tmr_state_t;
endpackage

// >>> logic/rtcc_tick_if.sv
// Interface carrying divider settings and tick outputs between modules
`timescale 1ns/10ps
`default_nettype none
interface rtcc_tick_if;
  logic [14:0] second_divider;
  logic [9:0] trim_delete_count;
  logic second_tick;
  logic trimmed_tick;
  modport ctrl (output second_divider, output trim_delete_count,
                input second_tick, input trimmed_tick);
  modport gen (input second_divider, input trim_delete_count,
               output second_tick, output trimmed_tick);
endinterface
`default_nettype wire

// >>> logic/rtcc_tick_gen.sv
// Trim deletion and second divider
`timescale 1ns/10ps
`default_nettype none
`include "rtcc_consts.svh"
module rtcc_tick_gen (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic slow_clock,
  rtcc_tick_if.gen tif
);
  import rtcc_pkg::*;
  logic slow_q;
  logic [9:0] period_q;
  logic [9:0] period_d;
  logic [9:0] deleted_q;
  logic [9:0] deleted_d;
  logic [14:0] div_q;
  logic [14:0] div_d;
  logic tick_q;
  logic trim_q;
  wire slow_edge = slow_clock & ~slow_q;
  wire period_end = (period_q == `RTCC_TRIM_PERIOD - 10'h001);
  // ---------------------------------------------------------------
  // Trim deletion
  // ---------------------------------------------------------------
  // pulse deletion window
  wire do_delete = (deleted_q < tif.trim_delete_count);
  wire kept = slow_edge & ~do_delete;
  assign period_d = period_end ? 10'h000 : period_q + 10'h001;
  assign deleted_d = period_end ? 10'h000 : (do_delete ? deleted_q + 10'h001 : deleted_q);
  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  // divide by field plus one
  wire div_end = (div_q >= tif.second_divider);
  assign div_d = div_end ? 15'h0000 : div_q + 15'h0001;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_q <= 1'b0;
      period_q <= 10'h000;
      deleted_q <= 10'h000;
      div_q <= 15'h0000;
      tick_q <= 1'b0;
      trim_q <= 1'b0;
    end else if (clk_en) begin
      slow_q <= slow_clock;
      trim_q <= kept;
      if (slow_edge) begin
        period_q <= period_d;
        deleted_q <= deleted_d;
      end
      tick_q <= 1'b0;
      if (kept) begin
        div_q <= div_d;
        tick_q <= div_end;
      end
    end
  end
  // zero divider passes every kept slow pulse
  assign tif.second_tick = tick_q;
  assign tif.trimmed_tick = trim_q;
endmodule
`default_nettype wire

// >>> logic/rtcc_top.sv
// RTC tick control, countdown timer and interrupt status with APB slave
//
// Overview of operation
// - Second tick comes every divider field plus one slow-clock cycles.
// - Divider zero: timer ticks each kept slow pulse; calendar tick stopped.
// - Divider resets to 0x7FFF, so 32768 slow cycles per tick.
// - Trim field deletes that many slow pulses per 1023-cycle period.
// - While calendar runs, divider and trim writes ignored; reads show values.
// - Writing calendar enable locks whole tick control until power-on reset.
// - Calendar enable reads back stored; resets to zero.
// - Enable bit 0 gates calendar interrupt; resets zero.
// - Enable bit 1 gates timer interrupt; resets zero.
// - Raw status shows calendar bit 0 and timer bit 1 unmasked.
// - Masked status is raw AND enable; drives interrupt outputs.
// - Writing one to clear bits clears interrupts; zero does nothing.
// - Calendar match never reported for out-of-range match values.
// - Timer at zero sets raw interrupt; periodic reloads, one-shot stops.
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "rtcc_consts.svh"
module rtcc_top #(
  parameter int TMR_WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic slow_clock,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] cal_seconds,
  input wire logic [5:0] cal_seconds_match,
  input wire logic [TMR_WIDTH-1:0] tmr_load,
  input wire logic tmr_start,
  input wire logic tmr_one_shot,
  output logic second_tick,
  output logic calendar_irq_out,
  output logic countdown_irq_out,
  output logic irq
);
  import rtcc_pkg::*;
  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [14:0] div_q;
  logic [9:0] trim_q;
  logic lock_q;
  rtcc_irq_t enable_q;
  rtcc_irq_t raw_q;
  rtcc_irq_t raw_d;
  logic [TMR_WIDTH-1:0] tmr_cnt_q;
  rtcc_tmr_state_t tmr_state_q;
  logic sec_prev_q;
  logic tick_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic cal_irq_q;
  logic tmr_irq_q;
  logic irq_q;
  rtcc_tick_if tif ();
  assign tif.second_divider = div_q;
  assign tif.trim_delete_count = trim_q;
  // Divider and trim run in their own module; settings travel in tif
  rtcc_tick_gen i_rtcc_tick_gen (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .slow_clock(slow_clock),
    .tif(tif)
  );
  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction
  wire setup = psel & ~penable;
  // Writes land on the access edge, where the master samples pready
  wire access = psel & penable & pready_q;
  wire wr = access & pwrite;
  // Read data latched in setup so it stands through access
  wire rd = setup & ~pwrite;
  wire sel_tc = hit(paddr, `RTCC_OFF_TICK_CONTROL);
  wire sel_en = hit(paddr, `RTCC_OFF_IRQ_ENABLE);
  wire sel_raw = hit(paddr, `RTCC_OFF_IRQ_RAW);
  wire sel_mis = hit(paddr, `RTCC_OFF_IRQ_MASKED);
  wire sel_clr = hit(paddr, `RTCC_OFF_IRQ_CLEAR);
  wire mapped = sel_tc | sel_en | sel_raw | sel_mis | sel_clr;
  wire wr_tc = wr & sel_tc & ~lock_q;
  wire wr_en = wr & sel_en;
  wire [1:0] clr = (wr & sel_clr) ? pwdata[1:0] : 2'b00;
  // ---------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------
  // calendar tick stopped with zero divider
  wire cal_tick = tif.second_tick & lock_q & (div_q != 15'h0000);
  wire match_ok = (cal_seconds_match < 6'h3c);
  wire cal_event = cal_tick & match_ok & (cal_seconds == cal_seconds_match);
  // timer follows slow pulses at zero divider
  wire tmr_tick = (div_q == 15'h0000) ? tif.trimmed_tick : tif.second_tick;
  wire tmr_run = (tmr_state_q == RTCC_TMR_RUN);
  wire tmr_zero = tmr_run & tmr_tick & (tmr_cnt_q == {TMR_WIDTH{1'b0}});
  assign raw_d = (raw_q & ~clr) | {tmr_zero, cal_event};
  wire [1:0] masked = raw_q & enable_q;
  wire [31:0] rd_tc = {5'h00, lock_q, trim_q, 1'b0, div_q};
  wire [31:0] rd_en = {30'h0, enable_q};
  wire [31:0] rd_raw = {30'h0, raw_q};
  wire [31:0] rd_mis = {30'h0, masked};
  // Clear register and unmapped offsets read as zero
  wire [31:0] rd_mux = sel_tc ? rd_tc :
                       sel_en ? rd_en :
                       sel_raw ? rd_raw :
                       sel_mis ? rd_mis : 32'h0000_0000;
  // ---------------------------------------------------------------
  // Tick control fields
  // ---------------------------------------------------------------
  // One short process per field keeps each write path easy to audit
  // reset divider
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= `RTCC_DIV_RESET;
    end else if (clk_en) begin
      if (wr_tc) begin
        div_q <= pwdata[`RTCC_DIV_MSB:`RTCC_DIV_LSB];
      end
    end
  end

  // Fields stored as written; the divider reads them every cycle
  // trim count store
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_q <= `RTCC_TRIM_RESET;
    end else if (clk_en) begin
      if (wr_tc) begin
        trim_q <= pwdata[`RTCC_TRIM_MSB:`RTCC_TRIM_LSB];
      end
    end
  end

  // Lock only ever sets: wr_tc is blocked once it is high
  // A write with the lock bit clear keeps the fields writable
  // lock resets clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_tc) begin
        lock_q <= pwdata[`RTCC_LOCK_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt enables
  // ---------------------------------------------------------------
  // Both enables share one word write; the lock does not touch them
  // calendar and timer enables
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= 2'b00;
    end else if (clk_en) begin
      if (wr_en) begin
        enable_q <= pwdata[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Countdown timer
  // ---------------------------------------------------------------
  // Load value is taken at start and again at every reload
  rtcc_tmr_state_t tmr_state_d;
  logic [TMR_WIDTH-1:0] tmr_cnt_d;
  // One count per tick; the tick that finds zero raises the flag
  always_comb begin
    tmr_state_d = tmr_state_q;
    tmr_cnt_d = tmr_cnt_q;
    case (tmr_state_q)
      RTCC_TMR_IDLE: begin
        if (tmr_start) begin
          tmr_cnt_d = tmr_load;
          tmr_state_d = RTCC_TMR_RUN;
        end
      end
      RTCC_TMR_RUN: begin
        if (tmr_zero) begin
          tmr_cnt_d = tmr_load;
          if (tmr_one_shot) begin
            tmr_state_d = RTCC_TMR_IDLE;
          end
        end else if (tmr_tick) begin
          tmr_cnt_d = tmr_cnt_q - {{(TMR_WIDTH-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        tmr_state_d = RTCC_TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_cnt_q <= TMR_WIDTH'(`RTCC_TMR_RESET);
    end else if (clk_en) begin
      tmr_cnt_q <= tmr_cnt_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_state_q <= RTCC_TMR_IDLE;
    end else if (clk_en) begin
      tmr_state_q <= tmr_state_d;
    end
  end

  // ---------------------------------------------------------------
  // Status and interrupt outputs
  // ---------------------------------------------------------------
  // Outputs trail masked status by one cycle so each leaves a flop
  // Clear acts only on bits written as one
  // sticky raw status
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_q <= 2'b00;
    end else if (clk_en) begin
      raw_q <= raw_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_irq_q <= 1'b0;
    end else if (clk_en) begin
      cal_irq_q <= masked[`RTCC_CAL_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_irq_q <= 1'b0;
    end else if (clk_en) begin
      tmr_irq_q <= masked[`RTCC_TMR_BIT];
    end
  end

  // Combined line for a single interrupt input upstream
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |masked;
    end
  end

  // Delayed copy widens the tick for slow observers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_prev_q <= 1'b0;
    end else if (clk_en) begin
      sec_prev_q <= tif.second_tick;
    end
  end

  // Two-cycle pulse per divided tick; the timer sees the narrow one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
    end else if (clk_en) begin
      tick_q <= tif.second_tick | sec_prev_q;
    end
  end

  // ---------------------------------------------------------------
  // Bus response
  // ---------------------------------------------------------------
  // No wait state, pready is high in the first access cycle, so every transfer has the same rhythm
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
    end else if (clk_en) begin
      pready_q <= setup;
    end
  end

  // Unmapped offsets answer with an error; read-only ones ignore writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      pslverr_q <= setup & ~mapped;
    end
  end

  // Holds the last read data between transfers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (rd) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output ports
  // ---------------------------------------------------------------
  // Straight from flops so no decode glitch reaches a pin
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign second_tick = tick_q;
  assign calendar_irq_out = cal_irq_q;
  assign countdown_irq_out = tmr_irq_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

// >>> sim/rtcc_top_props.sv
// Bus and interrupt pin checker
`timescale 1ns/10ps
`default_nettype none
module rtcc_top_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic second_tick,
  input wire logic calendar_irq_out,
  input wire logic countdown_irq_out,
  input wire logic irq
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  wire setup = psel && !penable;
  wire mapped = paddr inside {12'h018, 12'h01c, 12'h020, 12'h024, 12'h028};
  wire en_wr = psel && penable && pready && pwrite && paddr == 12'h01c;
  a_ready_follows: assert property (setup |=> pready) else $error("ready late");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held");
  a_err_unmapped: assert property (setup && !mapped |=> pslverr) else $error("no slverr");
  a_ok_mapped: assert property (setup && mapped |=> !pslverr) else $error("bad slverr");
  a_irq_joined: assert property (irq == (calendar_irq_out || countdown_irq_out))
    else $error("irq not or");
  a_cal_masked: assert property (en_wr && !pwdata[0] |-> ##2 !calendar_irq_out)
    else $error("cal not masked");
  a_tmr_masked: assert property (en_wr && !pwdata[1] |-> ##2 !countdown_irq_out)
    else $error("tmr not masked");
  a_tick_width: assert property ($rose(second_tick) |=> second_tick ##1 !second_tick)
    else $error("tick width");
  c_err: cover property (pready && pslverr);
  c_tick: cover property ($rose(second_tick));
  c_cal: cover property ($rose(calendar_irq_out));
  c_tmr: cover property ($rose(countdown_irq_out));
endmodule
bind rtcc_top rtcc_top_props i_rtcc_top_props (.sys_clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .second_tick, .calendar_irq_out, .countdown_irq_out, .irq);
`default_nettype wire

// >>> sim/rtcc_top_test.sv
// Directed bench for the tick control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, x, s) begin cmp_count++; if ((s) !== (x)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, (x), (s)); end end
module rtcc_top_test;
  logic sys_clk, rst_n, clk_en, slow_clock, psel, penable, pwrite, tmr_start, tmr_one_shot;
  logic pready, pslverr, second_tick, calendar_irq_out, countdown_irq_out, irq, e, tick_d1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, tmr_load, d;
  logic [5:0] cal_seconds, cal_seconds_match;
  int n_errors = 0, cmp_count = 0, n_ticks = 0, cyc = 0, t0;
  rtcc_top i_rtcc_top (.sys_clk, .rst_n, .clk_en, .slow_clock, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cal_seconds, .cal_seconds_match, .tmr_load,
    .tmr_start, .tmr_one_shot, .second_tick, .calendar_irq_out, .countdown_irq_out, .irq);
  // -------
  // Helpers
  // -------
  task automatic tally_and_finish;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Slow pulses far apart so the sync stage sees each one
  task automatic sp(input int n);
    repeat (n) begin
      slow_clock <= 1'b1;
      repeat (3) @(posedge sys_clk);
      slow_clock <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_reset;
    xfer(1'b0, 12'h018, 32'h0);
    `CHK("tick_control", 32'h0000_7fff, d)
    xfer(1'b0, 12'h01c, 32'h0);
    `CHK("irq_enable", 32'h0, d)
    xfer(1'b0, 12'h024, 32'h0);
    `CHK("irq_masked", 32'h0, d)
    xfer(1'b0, 12'h02c, 32'h0);
    `CHK("unmapped", 1'b1, e)
  endtask
  task automatic t_div;
    xfer(1'b1, 12'h018, 32'h0000_0001);
    t0 = n_ticks;
    sp(8);
    `CHK("ticks_div1", 4, n_ticks - t0)
    xfer(1'b1, 12'h018, 32'h03ff_0001);
    xfer(1'b0, 12'h018, 32'h0);
    `CHK("trim_rb", 32'h03ff_0001, d)
    t0 = n_ticks;
    sp(8);
    `CHK("ticks_trim", 0, n_ticks - t0)
  endtask
  task automatic t_timer(input logic os);
    tmr_one_shot <= os;
    tmr_start <= 1'b1;
    @(posedge sys_clk);
    tmr_start <= 1'b0;
    sp(6);
    xfer(1'b0, 12'h024, 32'h0);
    `CHK("tmr_masked", 32'h2, d)
    `CHK("tmr_out", 1'b1, countdown_irq_out)
    `CHK("irq_out", 1'b1, irq)
    xfer(1'b1, 12'h028, 32'h0);
    xfer(1'b0, 12'h020, 32'h0);
    `CHK("raw_kept", 32'h2, d)
    xfer(1'b1, 12'h028, 32'h2);
    sp(6);
    xfer(0, 12'h020, 32'h0);
    `CHK("raw_rerun", os ? 32'h0 : 32'h2, d)
    xfer(1'b1, 12'h028, 32'h2);
  endtask
  task automatic t_cal;
    xfer(1'b1, 12'h018, 32'h0400_0001);
    xfer(1'b1, 12'h018, 32'h0000_0005);
    xfer(1'b0, 12'h018, 32'h0);
    `CHK("locked", 32'h0400_0001, d)
    `CHK("lock_rb", 1'b1, d[26])
    `CHK("div_kept", 15'h0001, d[14:0])
    xfer(1'b1, 12'h01c, 32'h1);
    cal_seconds <= 6'h3c;
    cal_seconds_match <= 6'h3c;
    sp(6);
    xfer(1'b0, 12'h020, 32'h0);
    `CHK("cal_range", 1'b0, d[0])
    cal_seconds <= 6'h05;
    cal_seconds_match <= 6'h05;
    sp(6);
    xfer(1'b0, 12'h020, 32'h0);
    `CHK("cal_raw", 1'b1, d[0])
    `CHK("cal_out", 1'b1, calendar_irq_out)
    `CHK("tmr_off", 1'b0, countdown_irq_out)
    xfer(1'b1, 12'h01c, 32'h0);
    xfer(1'b1, 12'h028, 32'h1);
    xfer(1'b0, 12'h020, 32'h0);
    `CHK("cal_clr", 1'b0, d[0])
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    tick_d1 <= second_tick;
    if (second_tick && !tick_d1) n_ticks <= n_ticks + 1;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    {slow_clock, psel, penable, pwrite, tmr_start, tmr_one_shot} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    tmr_load = 32'h3;
    cal_seconds = 6'h00;
    cal_seconds_match = 6'h01;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_div;
    xfer(1'b1, 12'h018, 32'h0);
    xfer(1'b1, 12'h01c, 32'h2);
    t_timer(1'b1);
    t_timer(1'b0);
    t_cal;
    tally_and_finish;
  end
endmodule
`default_nettype wire
